/* File: design/eipu_pkg.sv */
/*
 * Constants for the external pin interrupt unit: register offsets,
 * field positions, reset values and the sense-mode enumeration.
 * Assumes a 32-bit AXI4-Lite register bus, one register per word.
 */
package eipu_pkg;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_SENSE_CONTROL  = 8'h00;
    localparam logic [7:0] OFF_CONTROL_STATUS = 8'h04;
    localparam logic [7:0] OFF_ENABLE         = 8'h08;
    localparam logic [7:0] OFF_FLAGS          = 8'h0C;
    localparam logic [7:0] OFF_CPU_STATUS     = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS     = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK       = 8'h18;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int LINE_ONE_SENSE_LSB  = 2;
    localparam int LINE_ZERO_SENSE_LSB = 0;
    localparam int LINE_TWO_EDGE_BIT   = 6;
    localparam int LINE_ONE_BIT        = 7;
    localparam int LINE_ZERO_BIT       = 6;
    localparam int LINE_TWO_BIT        = 5;
    localparam int GLOBAL_ENABLE_BIT   = 0;

    // ---------------------------------------------------------------
    // reset values and bus answers
    // ---------------------------------------------------------------
    localparam logic [1:0] SENSE_RESET = 2'h0;
    localparam logic [2:0] LINES_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // line index inside the three-bit vectors
    localparam int L0 = 0;
    localparam int L1 = 1;
    localparam int L2 = 2;

    // encoding follows declaration order: 0 low, 1 any, 2 fall, 3 rise
    typedef enum logic [1:0] {
        SENSE_LOW,
        SENSE_ANY,
        SENSE_FALL,
        SENSE_RISE
    } eipu_sense_e;

endpackage

/* File: design/eipu_top.sv */
/*
 * External pin interrupt unit: three pin lines, sense control, enables,
 * flags, per-line vector requests and an AXI4-Lite register slave.
 * Assumes pins synchronous to aclk for lines zero and one; line two is
 * captured on its own pin edge and handed over to aclk.
 */
`timescale 1ns/1ns

module eipu_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // external pins
    input  wire logic        ext_line_zero,
    input  wire logic        ext_line_one,
    input  wire logic        ext_line_two,
    // sleep controller: input buffers cut off
    input  wire logic        sleep_buf_off,
    // core vectoring: requests and routine-entry acknowledges
    output logic             vec_req_zero,
    output logic             vec_req_one,
    output logic             vec_req_two,
    input  wire logic        vec_ack_zero,
    input  wire logic        vec_ack_one,
    input  wire logic        vec_ack_two,
    // interrupt output
    output logic             irq,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            eipu_pkg::OFF_SENSE_CONTROL, eipu_pkg::OFF_CONTROL_STATUS,
            eipu_pkg::OFF_ENABLE, eipu_pkg::OFF_FLAGS,
            eipu_pkg::OFF_CPU_STATUS, eipu_pkg::OFF_IRQ_STATUS,
            eipu_pkg::OFF_IRQ_MASK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    // line vector to register byte layout
    function automatic logic [7:0] pack_lines(input logic [2:0] v);
        pack_lines = 8'h00;
        pack_lines[eipu_pkg::LINE_ZERO_BIT] = v[eipu_pkg::L0];
        pack_lines[eipu_pkg::LINE_ONE_BIT]  = v[eipu_pkg::L1];
        pack_lines[eipu_pkg::LINE_TWO_BIT]  = v[eipu_pkg::L2];
    endfunction

    function automatic logic [2:0] unpack_lines(input logic [7:0] b);
        unpack_lines = {b[eipu_pkg::LINE_TWO_BIT], b[eipu_pkg::LINE_ONE_BIT],
                        b[eipu_pkg::LINE_ZERO_BIT]};
    endfunction

    function automatic logic edge_hit(input eipu_pkg::eipu_sense_e m,
                                      input logic cur, input logic prev);
        case (m)
            eipu_pkg::SENSE_ANY:  edge_hit = cur ^ prev;
            eipu_pkg::SENSE_FALL: edge_hit = prev & ~cur;
            eipu_pkg::SENSE_RISE: edge_hit = cur & ~prev;
            default:              edge_hit = 1'b0;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    eipu_pkg::eipu_sense_e sense_zero_reg, sense_one_reg;
    logic        edge_sel_reg, gie_reg, two_cap_reg, two_s1_reg, two_s2_reg, two_ack_reg;
    logic        aw_full_reg, w_full_reg, w_lane_reg, wr_fire, wr_en, two_pin, two_edge_clk;
    logic [1:0]  sync1_reg, sync2_reg, prev_reg;
    logic [2:0]  en_reg, flag_reg, status_reg, mask_reg, set_evt, level_low;
    logic [2:0]  ack_vec, flag_clr, req_next;
    logic [7:0]  aw_addr_reg, w_data_reg;
    assign ack_vec = {vec_ack_two, vec_ack_one, vec_ack_zero};

    // ---------------------------------------------------------------
    // lines zero and one: sampling and edge detection
    // ---------------------------------------------------------------
    // two-stage synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 2'h3;
            sync2_reg <= 2'h3;
            prev_reg  <= 2'h3;
        end else begin
            sync1_reg <= {ext_line_one, ext_line_zero};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // compare sampled value with previous sample
    // raw pin level used, direction plays no part
    // edges need aclk; low-level path is purely combinational
    always_comb begin
        set_evt[eipu_pkg::L0]   = edge_hit(sense_zero_reg, sync2_reg[0], prev_reg[0]);
        set_evt[eipu_pkg::L1]   = edge_hit(sense_one_reg, sync2_reg[1], prev_reg[1]);
        set_evt[eipu_pkg::L2]   = two_s2_reg & ~two_ack_reg;
        level_low[eipu_pkg::L0] = (sense_zero_reg == eipu_pkg::SENSE_LOW) & ~ext_line_zero;
        level_low[eipu_pkg::L1] = (sense_one_reg == eipu_pkg::SENSE_LOW) & ~ext_line_one;
        level_low[eipu_pkg::L2] = 1'b0;
    end

    // ---------------------------------------------------------------
    // line two: capture on the pin edge itself
    // ---------------------------------------------------------------
    // disabled line two with buffer cut-off reads low
    assign two_pin = ext_line_two & ~(sleep_buf_off & ~en_reg[eipu_pkg::L2]);
    // select zero inverts so the falling edge becomes rising
    assign two_edge_clk = two_pin ^ ~edge_sel_reg;

    // no aclk needed; cleared only once aclk has seen it
    always_ff @(posedge two_edge_clk or posedge two_ack_reg) begin
        if (two_ack_reg)
            two_cap_reg <= 1'b0;
        else
            two_cap_reg <= 1'b1;
    end

    // ack held high in reset keeps the capture cleared
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            two_s1_reg  <= 1'b0;
            two_s2_reg  <= 1'b0;
            two_ack_reg <= 1'b1;
        end else begin
            two_s1_reg  <= two_cap_reg;
            two_s2_reg  <= two_s1_reg;
            two_ack_reg <= two_s2_reg;
        end
    end

    // ---------------------------------------------------------------
    // flags and requests
    // ---------------------------------------------------------------
    assign wr_en = wr_fire & w_lane_reg;

    always_comb begin
        flag_clr = ack_vec;
        if (wr_en && aw_addr_reg == eipu_pkg::OFF_FLAGS)
            flag_clr = ack_vec | unpack_lines(w_data_reg);
    end

    // event sets flag; set wins over clear
    // routine entry or written one clears
    // level mode holds flag at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= eipu_pkg::LINES_RESET;
        end else begin
            flag_reg <= ((flag_reg & ~flag_clr) | set_evt) & ~{1'b0,
                        sense_one_reg == eipu_pkg::SENSE_LOW,
                        sense_zero_reg == eipu_pkg::SENSE_LOW};
        end
    end

    // line enable and global enable both needed
    // flag or held low level raises the request
    // level request follows the pin continuously
    assign req_next = {3{gie_reg}} & en_reg & (flag_reg | level_low);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_req_zero <= 1'b0;
            vec_req_one  <= 1'b0;
            vec_req_two  <= 1'b0;
        end else begin
            vec_req_zero <= req_next[eipu_pkg::L0];
            vec_req_one  <= req_next[eipu_pkg::L1];
            vec_req_two  <= req_next[eipu_pkg::L2];
        end
    end

    // ---------------------------------------------------------------
    // interrupt status, mask and output
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= eipu_pkg::LINES_RESET;
            irq        <= 1'b0;
        end else begin
            if (wr_en && aw_addr_reg == eipu_pkg::OFF_IRQ_STATUS)
                status_reg <= (status_reg & ~w_data_reg[2:0]) | set_evt | level_low;
            else
                status_reg <= status_reg | set_evt | level_low;
            irq <= |(status_reg & mask_reg);
        end
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    // sense fields, line two edge select, enables, global enable and mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_zero_reg <= eipu_pkg::eipu_sense_e'(eipu_pkg::SENSE_RESET);
            sense_one_reg  <= eipu_pkg::eipu_sense_e'(eipu_pkg::SENSE_RESET);
            edge_sel_reg   <= 1'b0;
            en_reg         <= eipu_pkg::LINES_RESET;
            gie_reg        <= 1'b0;
            mask_reg       <= eipu_pkg::LINES_RESET;
        end else if (wr_en) begin
            case (aw_addr_reg)
                eipu_pkg::OFF_SENSE_CONTROL: begin
                    sense_zero_reg <= eipu_pkg::eipu_sense_e'(
                        w_data_reg[eipu_pkg::LINE_ZERO_SENSE_LSB +: 2]);
                    sense_one_reg  <= eipu_pkg::eipu_sense_e'(
                        w_data_reg[eipu_pkg::LINE_ONE_SENSE_LSB +: 2]);
                end
                eipu_pkg::OFF_CONTROL_STATUS:
                    edge_sel_reg <= w_data_reg[eipu_pkg::LINE_TWO_EDGE_BIT];
                eipu_pkg::OFF_ENABLE:     en_reg <= unpack_lines(w_data_reg);
                eipu_pkg::OFF_CPU_STATUS: gie_reg <= w_data_reg[eipu_pkg::GLOBAL_ENABLE_BIT];
                eipu_pkg::OFF_IRQ_MASK:   mask_reg <= w_data_reg[2:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite write channel
    // ---------------------------------------------------------------
    // address and data taken in either order; write once both held
    assign wr_fire = aw_full_reg & w_full_reg & ~bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awready     <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
            awready <= ~((awvalid & awready) | (aw_full_reg & ~wr_fire));
        end
    end

    // only the low byte lane carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wready     <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else begin
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata[7:0];
                w_lane_reg <= wstrb[0];
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
            wready <= ~((wvalid & wready) | (w_full_reg & ~wr_fire));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= eipu_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= addr_hit(aw_addr_reg) ? eipu_pkg::RESP_OKAY : eipu_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite read channel
    // ---------------------------------------------------------------
    logic [7:0] rd_byte;

    // level-mode flags read as zero since they never latch
    always_comb begin
        case (araddr)
            eipu_pkg::OFF_SENSE_CONTROL:  rd_byte = {4'h0, sense_one_reg, sense_zero_reg};
            eipu_pkg::OFF_CONTROL_STATUS: rd_byte = {1'b0, edge_sel_reg, 6'h00};
            eipu_pkg::OFF_ENABLE:     rd_byte = pack_lines(en_reg);
            eipu_pkg::OFF_FLAGS:      rd_byte = pack_lines(flag_reg);
            eipu_pkg::OFF_CPU_STATUS: rd_byte = {7'h00, gie_reg};
            eipu_pkg::OFF_IRQ_STATUS: rd_byte = {5'h00, status_reg};
            eipu_pkg::OFF_IRQ_MASK:   rd_byte = {5'h00, mask_reg};
            default:                  rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= eipu_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_byte};
            rresp   <= addr_hit(araddr) ? eipu_pkg::RESP_OKAY : eipu_pkg::RESP_SLVERR;
        end else if (rvalid) begin
            if (rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end else begin
            arready <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_line1_sense_write: assert property (
        wr_en && aw_addr_reg == eipu_pkg::OFF_SENSE_CONTROL
        |=> sense_one_reg == $past(w_data_reg[3:2]))
        else $error("line one sense field not written");
    a_line0_sense_write: assert property (
        wr_en && aw_addr_reg == eipu_pkg::OFF_SENSE_CONTROL
        |=> sense_zero_reg == $past(w_data_reg[1:0]))
        else $error("line zero sense field not written");
    a_sampled_rise: assert property (
        set_evt[0] && sense_zero_reg == eipu_pkg::SENSE_RISE
        && $past(sense_zero_reg) == eipu_pkg::SENSE_RISE
        |-> $past(ext_line_zero, 2) && !$past(ext_line_zero, 3))
        else $error("line zero rise not three cycles after pin");
    a_line2_event_flag: assert property (
        set_evt[2] |=> flag_reg[2] ##1 !set_evt[2])
        else $error("line two event did not set flag once");
    a_request_gate: assert property (
        vec_req_two |-> $past(gie_reg) && $past(en_reg[2]))
        else $error("line two request without both enables");
    a_flag_request: assert property (
        flag_reg[1] && gie_reg && en_reg[1] |=> vec_req_one)
        else $error("line one flag did not request vector");
    a_w1c_clear: assert property (
        wr_en && aw_addr_reg == eipu_pkg::OFF_FLAGS && w_data_reg[5]
        && !set_evt[2] |=> !flag_reg[2])
        else $error("written one did not clear line two flag");
    a_level_no_flag: assert property (
        sense_one_reg == eipu_pkg::SENSE_LOW |=> !flag_reg[1])
        else $error("line one flag latched in level mode");
    a_level_request: assert property (
        gie_reg && en_reg[0] && sense_zero_reg == eipu_pkg::SENSE_LOW
        && !ext_line_zero |=> vec_req_zero)
        else $error("level request dropped while pin low");
    a_irq_follow: assert property (
        (|(status_reg & mask_reg))[*2] |-> irq)
        else $error("irq low with unmasked status set");

endmodule

/* File: test/eipu_pin_src.sv */
/*
 * Pin source model for the three interrupt lines of the unit.
 * Assumes one bench process calls its task; pins idle high.
 */
`timescale 1ns/1ns
module eipu_pin_src (
    // clock
    input  wire logic aclk,
    // pins
    output logic      pin_zero,
    output logic      pin_one,
    output logic      pin_two
);
    initial begin
        pin_zero = 1'b1;
        pin_one  = 1'b1;
        pin_two  = 1'b1;
    end

    // level held for the whole count
    task automatic hold(input int line, input logic lvl, input int cycles);
        @(posedge aclk);
        case (line)
            0: pin_zero <= lvl;
            1: pin_one  <= lvl;
            default: pin_two <= lvl;
        endcase
        repeat (cycles) @(posedge aclk);
    endtask
endmodule

/* File: test/tb_eipu_top.sv */
/*
 * Self-checking bench for the external pin interrupt unit.
 * Assumes eipu_pin_src drives the pins and one bus access at a time.
 */
`timescale 1ns/1ns
module tb_eipu_top;
    logic        aclk, aresetn, sleep_buf_off, irq, pin_zero, pin_one, pin_two;
    logic        vec_req_zero, vec_req_one, vec_req_two;
    logic        vec_ack_zero, vec_ack_one, vec_ack_two;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr, lb;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [33:0] rd_q[$];
    logic [1:0]  b_q[$];
    logic [7:0]  rw_a[5];
    logic [7:0]  rw_v[5];
    int          mismatches, cmp_count, i, line, mode;
    integer      seed;

    eipu_top dut (.aclk(aclk), .aresetn(aresetn), .ext_line_zero(pin_zero),
        .ext_line_one(pin_one), .ext_line_two(pin_two), .sleep_buf_off(sleep_buf_off),
        .vec_req_zero(vec_req_zero), .vec_req_one(vec_req_one), .vec_req_two(vec_req_two),
        .vec_ack_zero(vec_ack_zero), .vec_ack_one(vec_ack_one), .vec_ack_two(vec_ack_two),
        .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    eipu_pin_src src (.aclk(aclk), .pin_zero(pin_zero), .pin_one(pin_one), .pin_two(pin_two));

    always #4 aclk = ~aclk;

    // ----------------------------------------------------------------
    // compare and report
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_sig(input logic got, input logic exp);
        chk_word({33'h0, got}, {33'h0, exp});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic hang;
        mismatches++;
        $display("bus wait ran out at %0t", $time);
        tally_and_finish();
    endtask

    // ----------------------------------------------------------------
    // bus master; answers are compared by the monitor below
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] resp = eipu_pkg::RESP_OKAY);
        int n;
        logic [31:0] r;
        r = $random(seed);
        b_q.push_back(resp);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {r[31:8], d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) hang();
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] resp = eipu_pkg::RESP_OKAY);
        int n;
        rd_q.push_back({resp, 24'h0, d});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) hang();
        rready <= 1'b0;
    endtask
    task automatic wait_neg(input int c);
        repeat (c) @(posedge aclk);
        @(negedge aclk);
    endtask

    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0) begin
            chk_word({rresp, rdata}, rd_q.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1 && b_q.size() > 0) begin
            chk_word({32'h0, bresp}, {32'h0, b_q.pop_front()});
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h4515A8EA;
        {aclk, aresetn, sleep_buf_off, vec_ack_zero, vec_ack_one, vec_ack_two} = '0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        rw_a = '{eipu_pkg::OFF_SENSE_CONTROL, eipu_pkg::OFF_CONTROL_STATUS,
            eipu_pkg::OFF_ENABLE, eipu_pkg::OFF_CPU_STATUS, eipu_pkg::OFF_IRQ_MASK};
        rw_v = '{8'h0F, 8'h40, 8'hE0, 8'h01, 8'h07};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 7; i++) rd(8'(i * 4), 8'h00);
        for (i = 0; i < 5; i++) begin
            wr(rw_a[i], 8'hFF);
            rd(rw_a[i], rw_v[i]);
            wr(rw_a[i], 8'h00);
        end
        rd(8'h1C, 8'h00, eipu_pkg::RESP_SLVERR);
        wr(8'h1C, 8'hFF, eipu_pkg::RESP_SLVERR);
        // low byte lane off: answered okay, register left alone
        wstrb <= 4'h0;
        wr(eipu_pkg::OFF_ENABLE, 8'hE0);
        wstrb <= 4'hF;
        rd(eipu_pkg::OFF_ENABLE, 8'h00);
        $display("test registers done");
        // every sense code on lines zero and one
        for (line = 0; line < 2; line++) for (mode = 0; mode < 4; mode++) begin
            lb = (line == 1) ? 8'h80 : 8'h40;
            wr(eipu_pkg::OFF_SENSE_CONTROL, 8'(mode << (2 * line)));
            wr(eipu_pkg::OFF_FLAGS, 8'hE0);
            src.hold(line, 1'b0, 4 + $unsigned($random(seed)) % 3);
            rd(eipu_pkg::OFF_FLAGS, (mode == 1 || mode == 2) ? lb : 8'h00);
            wr(eipu_pkg::OFF_FLAGS, 8'h00);
            rd(eipu_pkg::OFF_FLAGS, (mode == 1 || mode == 2) ? lb : 8'h00);
            wr(eipu_pkg::OFF_FLAGS, 8'hE0);
            src.hold(line, 1'b1, 4 + $unsigned($random(seed)) % 3);
            rd(eipu_pkg::OFF_FLAGS, (mode == 1 || mode == 3) ? lb : 8'h00);
        end
        $display("test sense modes done");
        wr(eipu_pkg::OFF_SENSE_CONTROL, 8'h0A);
        wr(eipu_pkg::OFF_ENABLE, 8'hE0);
        wr(eipu_pkg::OFF_FLAGS, 8'hE0);
        src.hold(0, 1'b0, 1);
        src.hold(1, 1'b0, 6);
        wait_neg(0);
        chk_sig(vec_req_zero, 1'b0);
        wr(eipu_pkg::OFF_CPU_STATUS, 8'h01);
        wait_neg(2);
        chk_sig(vec_req_zero, 1'b1);
        chk_sig(vec_req_two, 1'b0);
        @(posedge aclk) vec_ack_zero <= 1'b1;
        @(posedge aclk) vec_ack_zero <= 1'b0;
        wait_neg(2);
        chk_sig(vec_req_zero, 1'b0);
        chk_sig(vec_req_one, 1'b1);
        @(posedge aclk) vec_ack_one <= 1'b1;
        @(posedge aclk) vec_ack_one <= 1'b0;
        wait_neg(2);
        chk_sig(vec_req_one, 1'b0);
        src.hold(1, 1'b1, 1);
        wr(eipu_pkg::OFF_SENSE_CONTROL, 8'h00);
        src.hold(0, 1'b0, 3);
        for (i = 0; i < 6; i++) begin
            wait_neg(0);
            chk_sig(vec_req_zero, 1'b1);
        end
        src.hold(0, 1'b1, 3);
        wait_neg(0);
        chk_sig(vec_req_zero, 1'b0);
        $display("test vectors done");
        // disable, select edge, clear flag, enable
        wr(eipu_pkg::OFF_ENABLE, 8'h00);
        wr(eipu_pkg::OFF_CONTROL_STATUS, 8'h40);
        wr(eipu_pkg::OFF_FLAGS, 8'hE0);
        wr(eipu_pkg::OFF_ENABLE, 8'h20);
        src.hold(2, 1'b0, 7);
        rd(eipu_pkg::OFF_FLAGS, 8'h00);
        src.hold(2, 1'b1, 7);
        rd(eipu_pkg::OFF_FLAGS, 8'h20);
        wait_neg(0);
        chk_sig(vec_req_two, 1'b1);
        @(posedge aclk) vec_ack_two <= 1'b1;
        @(posedge aclk) vec_ack_two <= 1'b0;
        wait_neg(2);
        chk_sig(vec_req_two, 1'b0);
        wr(eipu_pkg::OFF_ENABLE, 8'h00);
        wr(eipu_pkg::OFF_CONTROL_STATUS, 8'h00);
        wr(eipu_pkg::OFF_FLAGS, 8'hE0);
        src.hold(2, 1'b0, 7);
        rd(eipu_pkg::OFF_FLAGS, 8'h20);
        src.hold(2, 1'b1, 7);
        wr(eipu_pkg::OFF_FLAGS, 8'hE0);
        sleep_buf_off <= 1'b1;
        wait_neg(6);
        rd(eipu_pkg::OFF_FLAGS, 8'h20);
        sleep_buf_off <= 1'b0;
        $display("test line two done");
        wr(eipu_pkg::OFF_IRQ_STATUS, 8'h07);
        wr(eipu_pkg::OFF_SENSE_CONTROL, 8'h02);
        src.hold(0, 1'b0, 6);
        rd(eipu_pkg::OFF_IRQ_STATUS, 8'h01);
        wait_neg(0);
        chk_sig(irq, 1'b0);
        wr(eipu_pkg::OFF_IRQ_MASK, 8'h01);
        wait_neg(1);
        chk_sig(irq, 1'b1);
        wr(eipu_pkg::OFF_IRQ_STATUS, 8'h01);
        wait_neg(1);
        chk_sig(irq, 1'b0);
        src.hold(0, 1'b1, 3);
        $display("test interrupt output done");
        tally_and_finish();
    end
endmodule
